// ---- logic/fipu_pkg.sv ----
package fipu_pkg;

  // Register offsets on the special-function register bus.
  localparam logic [7:0] CFG_OFS  = 8'he9;
  localparam logic [7:0] ADRL_OFS = 8'hea;
  localparam logic [7:0] ADRH_OFS = 8'heb;
  localparam logic [7:0] DATL_OFS = 8'hec;
  localparam logic [7:0] DATH_OFS = 8'hed;
  localparam logic [7:0] CLKR_OFS = 8'hee;

  // Reset values.
  localparam logic [7:0] CFG_RST  = 8'h34;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Configuration register field positions.
  localparam int LOCK_LSB  = 6;
  localparam int IDLE_BIT  = 5;
  localparam int RDY_BIT   = 4;
  localparam int WIDTH_BIT = 2;

  // Operation codes of the operation select field.
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_MASS  = 2'h1;
  localparam logic [1:0] OP_PAGE  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;

  // Unlock stages and the two key bytes.
  localparam logic [1:0] LK_LOCKED  = 2'h0;
  localparam logic [1:0] LK_STEP1   = 2'h1;
  localparam logic [1:0] LK_OPEN    = 2'h2;
  localparam logic [1:0] LK_BLOCKED = 2'h3;
  localparam logic [7:0] KEY_FIRST  = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // Clock range codes; codes above the last band fall into the lowest one.
  localparam logic [3:0] RANGE_LAST   = 4'ha;
  localparam logic [3:0] SHIFT_LOWEST = 4'hb;

  // Flash timing at the top band, converted to mclk cycles (8 ns period).
  localparam int TMR_W         = 22;
  localparam int CLK_PERIOD_NS = 8;
  localparam int READ_TIME_NS  = 40;
  localparam int PROG_TIME_NS  = 40000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam logic [TMR_W-1:0] READ_CYC  = 22'((READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PROG_CYC  = 22'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ERASE_CYC = 22'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG, ST_ERASE} fipu_state_t;

endpackage

// ---- logic/fipu_unlock.sv ----
`timescale 1ns/1ps
module fipu_unlock (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       consume,
  output logic      [1:0] stage
);

  logic [1:0] stage_reg;

  // Keys are only examined before the open stage; once open, the next data write is payload.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage_reg <= fipu_pkg::LK_LOCKED;
    end else if (stage_reg == fipu_pkg::LK_BLOCKED) begin
      stage_reg <= fipu_pkg::LK_BLOCKED;
    end else if (consume) begin
      stage_reg <= fipu_pkg::LK_LOCKED;
    end else if (enable && key_wr) begin
      case (stage_reg)
        fipu_pkg::LK_LOCKED: begin
          stage_reg <= (key_data == fipu_pkg::KEY_FIRST) ? fipu_pkg::LK_STEP1 : fipu_pkg::LK_BLOCKED;
        end
        fipu_pkg::LK_STEP1: begin
          stage_reg <= (key_data == fipu_pkg::KEY_SECOND) ? fipu_pkg::LK_OPEN : fipu_pkg::LK_BLOCKED;
        end
        default: begin
          stage_reg <= stage_reg;
        end
      endcase
    end
  end

  assign stage = stage_reg;

  // The first key step and the permanent block.
  a_key_first: assert property (@(posedge mclk) disable iff (!rst_n)
    enable && key_wr && !consume && stage_reg == fipu_pkg::LK_LOCKED && key_data == fipu_pkg::KEY_FIRST
    |=> stage_reg == fipu_pkg::LK_STEP1) else $error("First key did not advance the unlock stage.");
  a_block_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    stage_reg == fipu_pkg::LK_BLOCKED |=> stage_reg == fipu_pkg::LK_BLOCKED [*4])
    else $error("Blocked unlock stage was left before reset.");

endmodule

// ---- logic/fipu_timer.sv ----
`timescale 1ns/1ps
module fipu_timer (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      start,
  input  wire logic [fipu_pkg::TMR_W-1:0] base_cyc,
  input  wire logic [3:0]                range_code,
  output logic                           done
);

  logic [fipu_pkg::TMR_W-1:0] cnt_reg;
  logic [fipu_pkg::TMR_W-1:0] load;
  logic [3:0]                 shift;

  // A slower band means fewer mclk edges per unit of flash time, so each band halves the count.
  always_comb begin
    shift = (range_code > fipu_pkg::RANGE_LAST) ? fipu_pkg::SHIFT_LOWEST : range_code;
    load  = base_cyc >> shift;
    if (load == '0) begin
      load = 22'h000001;
    end
  end

  // Down counter; done pulses in the last counted cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= load;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 22'h000001;
    end
  end

  assign done = (cnt_reg == 22'h000001) && !start;

endmodule

// ---- logic/fipu_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - Nothing starts until the peripheral enable bit zero is set.
// - Byte mode moves one byte per operation, word mode moves two.
// - Configuration bit 2 low selects word mode, high selects byte mode.
// - The held address steps by one after each read or write.
// - Unlock stage reads 00 locked, 01 after 0xaa, 10 after 0x55.
// - A wrong key sets stage 11 and blocks writes and erases until reset.
// - Configuration bit 5 is high while the unit is idle.
// - Bit 4 equals idle except byte write, where it shows buffer space.
// - Operation field: 00 read, 01 mass erase, 10 page erase, 11 write.
// - In write mode, a data low write launches the write.
// - Requests while not ready are dropped, never queued.
// - High address byte gives bits 15:8, or the page number to erase.
// - Data high returns read bits 15:8 and supplies the upper write byte.
// - Data low returns bits 7:0 of the last read.
// - Four-bit clock range: 0000 top band, halving up to 1010, else lowest.
// - Page erase clears 512 contiguous addresses chosen by page number.
// - In word mode the address registers form a 15-bit word address.
module fipu_top #(
  parameter logic [fipu_pkg::TMR_W-1:0] PROG_CYC  = fipu_pkg::PROG_CYC,
  parameter logic [fipu_pkg::TMR_W-1:0] ERASE_CYC = fipu_pkg::ERASE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        periph_enable_reg_two_bit0,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic      [15:0] flash_addr,
  output logic      [15:0] flash_wdata,
  output logic             flash_word,
  output logic             flash_read,
  output logic             flash_program,
  output logic             flash_page_erase,
  output logic             flash_mass_erase,
  input  wire logic [15:0] flash_rdata
);

  fipu_pkg::fipu_state_t state_reg;

  logic [3:0]  cfg_ctrl_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [3:0]  range_reg;
  logic        pend_reg;
  logic [15:0] pend_data_reg;
  logic [7:0]  rdata_reg;
  logic [15:0] fl_addr_reg;
  logic [15:0] fl_wdata_reg;
  logic        fl_word_reg;
  logic [3:0]  fl_cmd_reg;
  logic [1:0]  unlock_stage;
  logic        unit_idle_flag;
  logic        buffer_ready_flag;
  logic        byte_width_select;
  logic        launch_byte;
  logic [1:0]  operation_select;
  logic        byte_write_mode;
  logic        unlocked;
  logic        cfg_wr;
  logic        adrl_wr;
  logic        adrh_wr;
  logic        datl_wr;
  logic        dath_wr;
  logic        clkr_wr;
  logic        from_pend;
  logic        pend_take;
  logic        start;
  logic [1:0]  start_op;
  logic [15:0] start_data;
  logic        consume;
  logic        tmr_done;
  logic [fipu_pkg::TMR_W-1:0] tmr_base;

  // One strobe per register; the bus has no read strobe, so reads have no side effects.
  // The bus signals are passed in, so every strobe follows the bus as soon as it moves.
  function automatic logic hit(input logic wr, input logic [7:0] ad, input logic [7:0] ofs);
    hit = wr && (ad == ofs);
  endfunction

  assign cfg_wr  = hit(sfr_wr, sfr_addr, fipu_pkg::CFG_OFS);
  assign adrl_wr = hit(sfr_wr, sfr_addr, fipu_pkg::ADRL_OFS);
  assign adrh_wr = hit(sfr_wr, sfr_addr, fipu_pkg::ADRH_OFS);
  assign datl_wr = hit(sfr_wr, sfr_addr, fipu_pkg::DATL_OFS);
  assign dath_wr = hit(sfr_wr, sfr_addr, fipu_pkg::DATH_OFS);
  assign clkr_wr = hit(sfr_wr, sfr_addr, fipu_pkg::CLKR_OFS);

  // Mode decode and the two status flags.
  assign byte_width_select = cfg_ctrl_reg[fipu_pkg::WIDTH_BIT];
  assign operation_select  = cfg_ctrl_reg[1:0];
  assign byte_write_mode   = byte_width_select && (operation_select == fipu_pkg::OP_WRITE);
  assign unit_idle_flag    = (state_reg == fipu_pkg::ST_IDLE);
  assign buffer_ready_flag = byte_write_mode ? !pend_reg : unit_idle_flag;
  assign unlocked          = (unlock_stage == fipu_pkg::LK_OPEN);
  // A launching config write carries its own width bit, since the stored bit lags by one cycle.
  assign launch_byte       = from_pend || (cfg_wr ? sfr_wdata[fipu_pkg::WIDTH_BIT] : byte_width_select);

  // A buffered byte goes out on the first idle cycle after the previous write ends.
  assign from_pend = unit_idle_flag && pend_reg;
  // Byte write while busy: the second buffer slot takes the byte if it is free.
  assign pend_take = periph_enable_reg_two_bit0 && datl_wr && byte_write_mode && unlocked
                     && !unit_idle_flag && !pend_reg;

  // Launch decision. Only an idle unit starts work; anything else is dropped here.
  always_comb begin
    start      = 1'b0;
    start_op   = fipu_pkg::OP_READ;
    start_data = data_reg;
    if (from_pend) begin
      start      = 1'b1;
      start_op   = fipu_pkg::OP_WRITE;
      start_data = pend_data_reg;
    end else if (periph_enable_reg_two_bit0 && unit_idle_flag) begin
      if (cfg_wr && (sfr_wdata[1:0] != fipu_pkg::OP_WRITE)) begin
        start    = (sfr_wdata[1:0] == fipu_pkg::OP_READ) || unlocked;
        start_op = sfr_wdata[1:0];
      end else if (datl_wr && (operation_select == fipu_pkg::OP_WRITE) && unlocked) begin
        start      = 1'b1;
        start_op   = fipu_pkg::OP_WRITE;
        start_data = {byte_width_select ? 8'h00 : data_reg[15:8], sfr_wdata};
      end
    end
  end

  // Each accepted write or erase spends the unlock; a read leaves it alone.
  assign consume = (start && !from_pend && (start_op != fipu_pkg::OP_READ)) || pend_take;

  fipu_unlock u_unlock (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .enable   (periph_enable_reg_two_bit0),
    .key_wr   (datl_wr),
    .key_data (sfr_wdata),
    .consume  (consume),
    .stage    (unlock_stage)
  );

  // Timer length per operation; the timer scales it by the clock range.
  always_comb begin
    case (start_op)
      fipu_pkg::OP_READ:  tmr_base = fipu_pkg::READ_CYC;
      fipu_pkg::OP_WRITE: tmr_base = PROG_CYC;
      default:            tmr_base = ERASE_CYC;
    endcase
  end

  fipu_timer u_timer (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .start      (start),
    .base_cyc   (tmr_base),
    .range_code (range_reg),
    .done       (tmr_done)
  );

  // Sequencer state.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= fipu_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        fipu_pkg::ST_IDLE: begin
          if (start) begin
            case (start_op)
              fipu_pkg::OP_READ:  state_reg <= fipu_pkg::ST_READ;
              fipu_pkg::OP_WRITE: state_reg <= fipu_pkg::ST_PROG;
              default:            state_reg <= fipu_pkg::ST_ERASE;
            endcase
          end
        end
        fipu_pkg::ST_READ, fipu_pkg::ST_PROG, fipu_pkg::ST_ERASE: begin
          if (tmr_done) begin
            state_reg <= fipu_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= fipu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Writable configuration bits 3:0; the reserved bit is stored as written.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_ctrl_reg <= fipu_pkg::CFG_RST[3:0];
    end else if (cfg_wr) begin
      cfg_ctrl_reg <= sfr_wdata[3:0];
    end
  end

  // Clock range register; upper nibble is not stored.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      range_reg <= fipu_pkg::BYTE_RST[3:0];
    end else if (clkr_wr) begin
      range_reg <= sfr_wdata[3:0];
    end
  end

  // Held address. A software write in the same cycle as a launch wins over the step.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_reg <= {fipu_pkg::BYTE_RST, fipu_pkg::BYTE_RST};
    end else if (adrl_wr) begin
      addr_reg[7:0] <= sfr_wdata;
    end else if (adrh_wr) begin
      addr_reg[15:8] <= sfr_wdata;
    end else if (start && (start_op == fipu_pkg::OP_READ || start_op == fipu_pkg::OP_WRITE)) begin
      addr_reg <= addr_reg + 16'h0001;
    end
  end

  // Data registers. Read results overwrite them; in byte mode only the low byte returns.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_reg <= {fipu_pkg::BYTE_RST, fipu_pkg::BYTE_RST};
    end else if (tmr_done && state_reg == fipu_pkg::ST_READ) begin
      data_reg[7:0] <= flash_rdata[7:0];
      if (fl_word_reg) begin
        data_reg[15:8] <= flash_rdata[15:8];
      end
    end else if (datl_wr) begin
      data_reg[7:0] <= sfr_wdata;
    end else if (dath_wr) begin
      data_reg[15:8] <= sfr_wdata;
    end
  end

  // Second slot of the byte write double buffer.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= '0;
    end else if (pend_take) begin
      pend_reg      <= 1'b1;
      pend_data_reg <= {8'h00, sfr_wdata};
    end else if (from_pend) begin
      pend_reg      <= 1'b0;
    end
  end

  // Flash array request, latched at launch and held for the whole operation.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fl_addr_reg  <= '0;
      fl_wdata_reg <= '0;
      fl_word_reg  <= 1'b0;
      fl_cmd_reg   <= 4'h0;
    end else if (start) begin
      fl_word_reg  <= !launch_byte;
      fl_wdata_reg <= start_data;
      fl_cmd_reg   <= 4'h1 << start_op;
      case (start_op)
        fipu_pkg::OP_PAGE: fl_addr_reg <= {addr_reg[14:8], 9'h000};
        fipu_pkg::OP_MASS: fl_addr_reg <= 16'h0000;
        default: begin
          fl_addr_reg <= launch_byte ? addr_reg : {addr_reg[14:0], 1'b0};
        end
      endcase
    end else if (tmr_done) begin
      fl_cmd_reg <= 4'h0;
    end
  end

  assign flash_addr       = fl_addr_reg;
  assign flash_wdata      = fl_wdata_reg;
  assign flash_word       = fl_word_reg;
  assign flash_read       = fl_cmd_reg[fipu_pkg::OP_READ];
  assign flash_mass_erase = fl_cmd_reg[fipu_pkg::OP_MASS];
  assign flash_page_erase = fl_cmd_reg[fipu_pkg::OP_PAGE];
  assign flash_program    = fl_cmd_reg[fipu_pkg::OP_WRITE];

  // Read data is registered, so it appears one cycle after the address; unmapped reads give zero.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg <= fipu_pkg::BYTE_RST;
    end else begin
      case (sfr_addr)
        fipu_pkg::CFG_OFS:  rdata_reg <= {unlock_stage, unit_idle_flag, buffer_ready_flag, cfg_ctrl_reg};
        fipu_pkg::ADRL_OFS: rdata_reg <= addr_reg[7:0];
        fipu_pkg::ADRH_OFS: rdata_reg <= addr_reg[15:8];
        fipu_pkg::DATL_OFS: rdata_reg <= data_reg[7:0];
        fipu_pkg::DATH_OFS: rdata_reg <= data_reg[15:8];
        fipu_pkg::CLKR_OFS: rdata_reg <= {4'h0, range_reg};
        default:            rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = rdata_reg;

  // Launch gating.
  a_enable_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !periph_enable_reg_two_bit0 && !pend_reg |-> !start) else $error("Operation launched while disabled.");
  a_lock_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
    start && !from_pend && start_op != fipu_pkg::OP_READ |-> unlock_stage == fipu_pkg::LK_OPEN)
    else $error("Write or erase launched without unlock.");
  a_busy_cancel: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_wr && !unit_idle_flag && !tmr_done |=> $stable(flash_addr) && !unit_idle_flag)
    else $error("Request accepted while busy.");

  // Operation decode and flash request contents.
  a_mass_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    start && start_op == fipu_pkg::OP_MASS |=> flash_mass_erase && !flash_program && flash_addr == 16'h0000)
    else $error("Mass erase not issued as decoded.");
  a_page_target: assert property (@(posedge mclk) disable iff (!rst_n)
    start && start_op == fipu_pkg::OP_PAGE
    |=> flash_page_erase && flash_addr[8:0] == 9'h000 && flash_addr[15:9] == $past(addr_reg[14:8]))
    else $error("Page erase aimed at wrong block.");
  a_width_pick: assert property (@(posedge mclk) disable iff (!rst_n)
    start && !from_pend |=> flash_word == !cfg_ctrl_reg[fipu_pkg::WIDTH_BIT])
    else $error("Transfer width does not follow the width select.");
  a_write_launch: assert property (@(posedge mclk) disable iff (!rst_n)
    periph_enable_reg_two_bit0 && datl_wr && unit_idle_flag && !pend_reg && unlocked
    && operation_select == fipu_pkg::OP_WRITE |=> flash_program && !unit_idle_flag)
    else $error("Data write did not launch the flash write.");

  // Address step, read return and status flags.
  a_addr_step: assert property (@(posedge mclk) disable iff (!rst_n)
    start && (start_op == fipu_pkg::OP_READ || start_op == fipu_pkg::OP_WRITE) && !adrl_wr && !adrh_wr
    |=> addr_reg == $past(addr_reg) + 16'h0001) else $error("Address did not step after transfer.");
  a_read_return: assert property (@(posedge mclk) disable iff (!rst_n)
    tmr_done && state_reg == fipu_pkg::ST_READ |=> data_reg[7:0] == $past(flash_rdata[7:0]) && unit_idle_flag)
    else $error("Read data not returned in data low.");
  a_ready_match: assert property (@(posedge mclk) disable iff (!rst_n)
    !byte_write_mode |-> buffer_ready_flag == unit_idle_flag) else $error("Ready differs from idle.");

  // Double buffer hand-over and busy timing.
  a_pend_launch: assert property (@(posedge mclk) disable iff (!rst_n)
    pend_reg && unit_idle_flag |=> flash_program && !pend_reg)
    else $error("Buffered byte was not launched on the idle cycle.");
  a_pend_byte: assert property (@(posedge mclk) disable iff (!rst_n)
    from_pend |=> flash_program && !flash_word && flash_wdata[15:8] == 8'h00)
    else $error("Buffered byte not written as a single byte.");
  a_busy_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !unit_idle_flag && !tmr_done |=> !unit_idle_flag)
    else $error("Idle raised before the timed operation ended.");

endmodule

// ---- testbench/fipu_flash_model.sv ----
`timescale 1ns/1ps
// Flash array stand-in; the erased level is an arbitrary choice of this model.
module fipu_flash_model #(
  parameter logic [7:0] ERASED = 8'hff
) (
  input  wire logic        mclk,
  input  wire logic [15:0] flash_addr,
  input  wire logic [15:0] flash_wdata,
  input  wire logic        flash_word,
  input  wire logic        flash_read,
  input  wire logic        flash_program,
  input  wire logic        flash_page_erase,
  input  wire logic        flash_mass_erase,
  output logic      [15:0] flash_rdata
);
  logic [7:0]  mem [0:65535];
  logic [15:0] junk;
  logic [2:0]  st_q;
  // Address pattern so that neighbouring bytes always differ.
  initial begin
    junk = 16'h5a5a;
    st_q = 3'h0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 7 + 3);
  end
  // Outside a read the bus toggles every cycle, so stale data can never match.
  assign flash_rdata = flash_read ? {mem[16'(flash_addr + 1)], mem[flash_addr]} : junk;
  // Each operation acts once, on the rising edge of its strobe.
  always @(posedge mclk) begin
    junk <= ~junk;
    st_q <= {flash_program, flash_page_erase, flash_mass_erase};
    if (flash_program && !st_q[2]) begin
      mem[flash_addr] <= flash_wdata[7:0];
      if (flash_word) mem[16'(flash_addr + 1)] <= flash_wdata[15:8];
    end
    if (flash_page_erase && !st_q[1]) for (int i = 0; i < 512; i++) mem[{flash_addr[15:9], 9'(i)}] <= ERASED;
    if (flash_mass_erase && !st_q[0]) for (int i = 0; i < 65536; i++) mem[i] <= ERASED;
  end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench; a byte-array reference of the flash gives every expected read-back byte.
module testbench;
  logic        mclk;
  logic        rst_n;
  logic        periph_enable_reg_two_bit0;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [15:0] flash_addr;
  logic [15:0] flash_wdata;
  logic        flash_word;
  logic        flash_read;
  logic        flash_program;
  logic        flash_page_erase;
  logic        flash_mass_erase;
  logic [15:0] flash_rdata;
  logic [7:0]  ref_mem [0:65535];
  logic [7:0]  v;
  logic [7:0]  l;
  logic [7:0]  d;
  logic [15:0] a;
  logic [15:0] cap_a;
  logic [15:0] cap_d;
  logic        cap_w;
  int          fails = 0;
  int          comparisons = 0;
  int          n;
  int          e;
  int          rl [5] = '{0, 1, 3, 4, 12};

  fipu_top #(.PROG_CYC(22'h000014), .ERASE_CYC(22'h000028)) fipu_top_i (
    .mclk, .rst_n, .periph_enable_reg_two_bit0, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .flash_addr, .flash_wdata, .flash_word, .flash_read, .flash_program, .flash_page_erase,
    .flash_mass_erase, .flash_rdata);
  fipu_flash_model fipu_flash_model_i (
    .mclk, .flash_addr, .flash_wdata, .flash_word, .flash_read, .flash_program,
    .flash_page_erase, .flash_mass_erase, .flash_rdata);

  // Free-running 125 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic conclude;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One register write; the strobe drops after a single edge.
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge mclk) #1;
    sfr_addr = ad;
    sfr_wdata = wd;
    sfr_wr = 1'b1;
    @(posedge mclk) #1;
    sfr_wr = 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address.
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk) #1;
    sfr_addr = ad;
    @(posedge mclk) #1;
    v = sfr_rdata;
  endtask

  task automatic unlock;
    wr(8'hec, 8'haa);
    rd(8'he9);
    chk(v[7:6], 2'b01);
    wr(8'hec, 8'h55);
    rd(8'he9);
    chk(v[7:6], 2'b10);
  endtask

  // Counts strobe cycles in a fixed window and captures the first busy cycle; busy at the end is a hang.
  task automatic span(input int win);
    n = 0;
    repeat (win) begin
      if ((flash_read | flash_program | flash_page_erase | flash_mass_erase) === 1'b1) begin
        if (n == 0) begin
          cap_a = flash_addr;
          cap_d = flash_wdata;
          cap_w = flash_word;
        end
        n++;
      end
      @(posedge mclk) #1;
    end
    if ((flash_read | flash_program | flash_page_erase | flash_mass_erase) !== 1'b0) begin
      chk({12'h000, flash_read, flash_program, flash_page_erase, flash_mass_erase}, 16'h0000);
      conclude;
    end
  endtask

  task automatic do_read(input logic [15:0] ra, input logic bm);
    logic [15:0] ea;
    ea = bm ? ra : {ra[14:0], 1'b0};
    wr(8'heb, ra[15:8]);
    wr(8'hea, ra[7:0]);
    wr(8'he9, {5'h00, bm, 2'b00});
    span(60);
    chk(n, 5);
    chk(cap_a, ea);
    chk(cap_w, !bm);
    rd(8'hec);
    chk(v, ref_mem[ea]);
    rd(8'hed);
    if (!bm) chk(v, ref_mem[16'(ea + 1)]);
    rd(8'hea);
    l = v;
    rd(8'heb);
    chk({v, l}, 16'(ra + 1));
    rd(8'he9);
    chk(v, bm ? 8'h34 : 8'h30);
  endtask

  initial begin
    rst_n = 1'b0;
    periph_enable_reg_two_bit0 = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    void'($urandom(32'h11ef));
    for (int i = 0; i < 65536; i++) ref_mem[i] = 8'(i * 7 + 3);
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    // Reset values, with the unmapped address below the block first.
    for (int i = 0; i < 7; i++) begin
      rd(8'(8'he8 + i));
      chk(v, (i == 1) ? 16'h34 : 16'h0);
    end
    // A read request while disabled must start nothing.
    wr(8'he9, 8'h04);
    span(20);
    chk(n, 0);
    periph_enable_reg_two_bit0 = 1'b1;
    for (int i = 0; i < 4; i++) do_read(16'($urandom) & 16'h7fff, i[0]);
    // Byte writes over several clock ranges; the address steps on its own.
    wr(8'he9, 8'h07);
    a = 16'($urandom);
    wr(8'heb, a[15:8]);
    wr(8'hea, a[7:0]);
    foreach (rl[k]) begin
      wr(8'hee, {4'($urandom), 4'(rl[k])});
      rd(8'hee);
      chk(v, rl[k]);
      unlock;
      d = 8'($urandom);
      wr(8'hec, d);
      span(60);
      e = 20 >> ((rl[k] > 11) ? 11 : rl[k]);
      if (e == 0) e = 1;
      chk(n, e);
      chk(cap_a, 16'(a + k));
      chk(cap_d, {8'h00, d});
      ref_mem[16'(a + k)] = d;
    end
    wr(8'hee, 8'h00);
    // A second byte handed over while the first is still programming.
    unlock;
    wr(8'hec, 8'h3c);
    unlock;
    wr(8'hec, 8'hc3);
    rd(8'he9);
    chk(v[5:4], 2'b00);
    span(80);
    ref_mem[16'(a + 5)] = 8'h3c;
    ref_mem[16'(a + 6)] = 8'hc3;
    for (int i = 0; i < 7; i++) do_read(16'(a + i), 1'b1);
    // Word write: upper byte first, the low byte launches it.
    wr(8'he9, 8'h03);
    a = 16'($urandom) & 16'h7fff;
    wr(8'heb, a[15:8]);
    wr(8'hea, a[7:0]);
    wr(8'hed, 8'ha5);
    unlock;
    wr(8'hec, 8'h5a);
    span(60);
    chk(cap_a, {a[14:0], 1'b0});
    chk(cap_d, 16'ha55a);
    chk(cap_w, 1'b1);
    ref_mem[{a[14:0], 1'b0}] = 8'h5a;
    ref_mem[{a[14:0], 1'b1}] = 8'ha5;
    do_read(a, 1'b0);
    // Page erase of a random page.
    a = 16'($urandom % 128);
    unlock;
    wr(8'hea, 8'h00);
    wr(8'heb, a[7:0]);
    wr(8'he9, 8'h02);
    span(60);
    chk(n, 40);
    chk(cap_a, {a[6:0], 9'h000});
    rd(8'he9);
    chk(v[7:6], 2'b00);
    for (int i = 0; i < 512; i++) ref_mem[{a[6:0], 9'(i)}] = 8'hff;
    do_read({a[6:0], 9'h1ff}, 1'b1);
    // Mass erase; a read asked for meanwhile is dropped, not queued.
    unlock;
    wr(8'he9, 8'h01);
    wr(8'he9, 8'h04);
    span(60);
    chk(n, 38);
    for (int i = 0; i < 65536; i++) ref_mem[i] = 8'hff;
    do_read(16'($urandom), 1'b1);
    // A wrong key blocks erasing until the next reset.
    wr(8'hec, 8'h12);
    rd(8'he9);
    chk(v[7:6], 2'b11);
    wr(8'hec, 8'haa);
    wr(8'hec, 8'h55);
    wr(8'he9, 8'h01);
    span(60);
    chk(n, 0);
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(8'he9);
    chk(v, 8'h34);
    conclude;
  end
endmodule
